/* File: inc/smiarb_defs.vh */
// Purpose: constants of the management interrupt arbiter
// Assumes: one clock, synchronous active-high reset
// Notes:   offsets are relative to the power management I/O base
`ifndef SMIARB_DEFS_VH
`define SMIARB_DEFS_VH

`define SMIARB_STATUS_OFS    8'h34
`define SMIARB_CONTROL_OFS   8'h30
`define SMIARB_STATUS_RST    32'h00000000
`define SMIARB_CONTROL_RST   32'h00000000
`define SMIARB_CONTROL_MASK  32'h0006000F

`define SMIARB_CTL_GBL       0
`define SMIARB_CTL_REARM     1
`define SMIARB_CTL_REL       2
`define SMIARB_CTL_LEG       3
`define SMIARB_CTL_LEG2      17
`define SMIARB_CTL_VND2      18

`define SMIARB_STS_TW        16
`define SMIARB_STS_LEG2      17
`define SMIARB_STS_VND2      18

`define SMIARB_GAP_LAST      2'h3
`define SMIARB_SETTLE_LAST   2'h3

`endif

/* File: verification/smiarb_chk.sv */
// Purpose: port assertions of the arbiter
// Assumes: one clock, sync reset
// Notes: enable shadowed from writes
`timescale 1ns/1ps
module smiarb_chk (
  input        clk_sys,
  input        sys_rst,
  input [7:0]  io_addr,
  input        io_wr,
  input        io_rd,
  input [31:0] io_wdata,
  input [31:0] io_rdata,
  input [7:0]  ehci_vendor_sts,
  input [7:0]  ehci_vendor_en,
  input [7:0]  ehci_legacy_sts,
  input [7:0]  ehci_legacy_en,
  input        system_mgmt_irq_n
);
  reg  gbl_q;
  wire rearm_w = io_wr && io_addr == 8'h30 && io_wdata[1];
  wire sts_rd  = io_rd && io_addr == 8'h34;
  wire irq     = !system_mgmt_irq_n;
  always @(posedge clk_sys)
    if (sys_rst)
      gbl_q <= 1'b0;
    else if (io_wr && io_addr == 8'h30)
      gbl_q <= io_wdata[0];
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence gap5;
    system_mgmt_irq_n [*5];
  endsequence
  a_gbl_gates: assert property ($rose(irq) |-> $past(gbl_q))
    else $error("irq while disabled");
  a_hold_low: assert property (irq && !rearm_w |=> irq)
    else $error("irq dropped early");
  a_rearm_rise: assert property (irq && rearm_w |=> gap5)
    else $error("rearm gap short");
  a_fall_gap: assert property ($fell(irq) |-> gap5)
    else $error("high gap short");
  a_rsv_zero: assert property (sts_rd |=> io_rdata[31:19] == 13'h0)
    else $error("reserved bits set");
  a_vendor_sum: assert property (sts_rd |=>
    io_rdata[18] == $past(|(ehci_vendor_sts & ehci_vendor_en)))
    else $error("vendor summary wrong");
  a_legacy_sum: assert property (sts_rd |=>
    io_rdata[17] == $past(|(ehci_legacy_sts & ehci_legacy_en)))
    else $error("legacy summary wrong");
  a_unmapped_rd: assert property (io_rd && io_addr != 8'h30 &&
    io_addr != 8'h34 |=> io_rdata == 32'h0)
    else $error("unmapped read nonzero");
endmodule // smiarb_chk
bind smiarb_top smiarb_chk i_smiarb_chk (.clk_sys, .sys_rst, .io_addr,
  .io_wr, .io_rd, .io_wdata, .io_rdata, .ehci_vendor_sts, .ehci_vendor_en,
  .ehci_legacy_sts, .ehci_legacy_en, .system_mgmt_irq_n);

/* File: verification/smiarb_host.sv */
// Purpose: host model, counts interrupts
// Assumes: clk_sys sampling
// Notes: handler steps come from tb
`timescale 1ns/1ps
module smiarb_host (
  input  wire       clk_sys,
  input  wire       sys_rst,
  input  wire       system_mgmt_irq_n,
  output reg  [7:0] irq_cnt
);
  reg prev_q;
  always @(posedge clk_sys) begin
    prev_q <= system_mgmt_irq_n | sys_rst;
    if (sys_rst)
      irq_cnt <= 8'h00;
    else if (prev_q & ~system_mgmt_irq_n)
      irq_cnt <= irq_cnt + 8'h01;
  end
endmodule // smiarb_host

/* File: verification/tb.sv */
// Purpose: self-checking bench of the arbiter
// Assumes: inputs change at falling edge
// Notes: host model counts interrupts
`timescale 1ns/1ps
module tb;
  reg clk_sys = 0, sys_rst = 1, io_wr = 0, io_rd = 0;
  reg [7:0] io_addr = 0, ehci_vendor_sts = 0, ehci_vendor_en = 0;
  reg [7:0] ehci_legacy_sts = 0, ehci_legacy_en = 0;
  reg [31:0] io_wdata = 0;
  reg legacy_usb_event = 0, global_release_bit = 0, other_smi_event = 0;
  reg tw_msg_toggle = 0, tw_alert_active = 0, twowire_smi_enable = 0;
  reg alert_disable = 0;
  wire [31:0] io_rdata;
  wire [7:0] irq_cnt;
  wire system_mgmt_irq_n;
  integer err_total = 0, total_checks = 0, n;
  smiarb_top i_smiarb_top (.clk_sys, .sys_rst, .io_addr, .io_wr, .io_rd,
    .io_wdata, .io_rdata, .legacy_usb_event, .global_release_bit,
    .ehci_vendor_sts, .ehci_vendor_en, .ehci_legacy_sts, .ehci_legacy_en,
    .other_smi_event, .tw_msg_toggle, .tw_alert_active,
    .twowire_smi_enable, .alert_disable, .system_mgmt_irq_n);
  smiarb_host i_smiarb_host (.clk_sys, .sys_rst, .system_mgmt_irq_n,
    .irq_cnt);
  initial forever #2 clk_sys = ~clk_sys;
  task chk(input [31:0] g, e);
    begin
      total_checks = total_checks + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("unexpected %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      io_addr = a;
      io_wdata = d;
      io_wr = 1;
      @(negedge clk_sys);
      io_wr = 0;
      @(negedge clk_sys);
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      io_addr = a;
      io_rd = 1;
      @(negedge clk_sys);
      io_rd = 0;
      @(negedge clk_sys);
      chk(io_rdata, e);
    end
  endtask
  task irq_is(input [31:0] e);
    begin
      n = 0;
      while (system_mgmt_irq_n !== 1'b0 && n < 20) begin
        @(negedge clk_sys);
        n = n + 1;
      end
      chk(system_mgmt_irq_n, e);
    end
  endtask
  task pulse_rel;
    begin
      global_release_bit = 1;
      @(negedge clk_sys);
      global_release_bit = 0;
    end
  endtask
  task s_first;
    begin
      rd(8'h34, 32'h0);
      rd(8'h44, 32'h0);
      other_smi_event = 1;
      irq_is(32'h1);
      wr(8'h30, 32'h1);
      irq_is(32'h0);
    end
  endtask
  task s_rearm;
    begin
      other_smi_event = 0;
      legacy_usb_event = 1;
      wr(8'h30, 32'hB);
      irq_is(32'h0);
      // one high cycle inside wr, n after it
      chk(n + 1, 32'h5);
      rd(8'h30, 32'h9);
      wr(8'h30, 32'h3);
      irq_is(32'h1);
      legacy_usb_event = 0;
      pulse_rel;
      irq_is(32'h1);
      wr(8'h30, 32'h7);
      pulse_rel;
      irq_is(32'h0);
    end
  endtask
  task s_status;
    begin
      ehci_vendor_sts = 8'h05;
      ehci_vendor_en = 8'h04;
      ehci_legacy_sts = 8'h0A;
      ehci_legacy_en = 8'h05;
      wr(8'h34, 32'h60000);
      rd(8'h34, 32'h40000);
      ehci_legacy_en = 8'h02;
      rd(8'h34, 32'h60000);
      wr(8'h30, 32'h20003);
      irq_is(32'h0);
      ehci_vendor_sts = 8'h00;
      ehci_legacy_sts = 8'h00;
      wr(8'h30, 32'h3);
      tw_msg_toggle = 1;
      irq_is(32'h0);
      rd(8'h34, 32'h10000);
      repeat (3908) @(negedge clk_sys);
      wr(8'h34, 32'h10000);
      rd(8'h34, 32'h0);
      twowire_smi_enable = 1;
      alert_disable = 1;
      tw_alert_active = 1;
      repeat (6) @(negedge clk_sys);
      rd(8'h34, 32'h0);
      tw_alert_active = 0;
      alert_disable = 0;
      repeat (6) @(negedge clk_sys);
      tw_alert_active = 1;
      repeat (6) @(negedge clk_sys);
      rd(8'h34, 32'h10000);
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  initial begin
    #60000;
    err_total = err_total + 1;
    end_sim;
  end
  initial begin
    repeat (4) @(negedge clk_sys);
    sys_rst = 0;
    s_first;
    s_rearm;
    s_status;
    chk(irq_cnt, 8'h05);
    end_sim;
  end
endmodule // tb

/* File: verilog/smiarb_sync.v */
// Purpose: two-flop synchroniser for one level
// Assumes: input from a slow foreign domain
// Notes:   only the second stage may be read
`timescale 1ns/1ps
module smiarb_sync (
  input  wire clk_sys,
  input  wire sys_rst,
  input  wire async_in,
  output reg  sync_out
);
  reg meta_q;

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      meta_q   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // smiarb_sync

/* File: verilog/smiarb_top.v */
// Purpose: management interrupt arbiter with control and status bits
// Assumes: I/O port accesses are one-cycle strobes on clk_sys
// Notes:   two-wire events arrive from a 64 kHz domain
`timescale 1ns/1ps
`include "smiarb_defs.vh"
module smiarb_top (
  input  wire        clk_sys,
  input  wire        sys_rst,
  input  wire [7:0]  io_addr,
  input  wire        io_wr,
  input  wire        io_rd,
  input  wire [31:0] io_wdata,
  output reg  [31:0] io_rdata,
  input  wire        legacy_usb_event,
  input  wire        global_release_bit,
  input  wire [7:0]  ehci_vendor_sts,
  input  wire [7:0]  ehci_vendor_en,
  input  wire [7:0]  ehci_legacy_sts,
  input  wire [7:0]  ehci_legacy_en,
  input  wire        other_smi_event,
  input  wire        tw_msg_toggle,
  input  wire        tw_alert_active,
  input  wire        twowire_smi_enable,
  input  wire        alert_disable,
  output reg         system_mgmt_irq_n
);
  // ****************************************
  // states
  // ****************************************
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_ASRT = 2'b01;
  localparam [1:0] ST_GAP  = 2'b10;

  reg [31:0] ctl_q;
  reg        tw_sts_q;
  reg        rel_pend_q;
  reg        first_done_q;
  reg [1:0]  state_q;
  reg [1:0]  gap_cnt_q;
  reg        msg_prev_q;
  reg        alert_prev_q;
  reg [1:0]  settle_q;
  wire       msg_sync;
  wire       alert_sync;

  // ****************************************
  // two-wire domain crossing
  // ****************************************
  smiarb_sync u_msg_sync (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .async_in (tw_msg_toggle),
    .sync_out (msg_sync)
  );

  smiarb_sync u_alert_sync (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .async_in (tw_alert_active),
    .sync_out (alert_sync)
  );

  // ****************************************
  // synchroniser settle after reset
  // ****************************************
  // ignore edges until flops settle
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      settle_q <= 2'h0;
    end else if (settle_q != `SMIARB_SETTLE_LAST) begin
      settle_q <= settle_q + 2'h1;
    end
  end

  wire tw_armed  = (settle_q == `SMIARB_SETTLE_LAST);
  wire msg_evt   = tw_armed & (msg_sync ^ msg_prev_q);
  wire alert_evt = tw_armed & alert_sync & ~alert_prev_q;

  // ****************************************
  // decode and summaries
  // ****************************************
  wire wr_ctl = io_wr & (io_addr == `SMIARB_CONTROL_OFS);
  wire wr_sts = io_wr & (io_addr == `SMIARB_STATUS_OFS);
  wire ctl_gbl   = ctl_q[`SMIARB_CTL_GBL];
  wire ctl_rearm = ctl_q[`SMIARB_CTL_REARM];
  wire ctl_rel   = ctl_q[`SMIARB_CTL_REL];
  wire ctl_leg   = ctl_q[`SMIARB_CTL_LEG];
  wire ctl_leg2  = ctl_q[`SMIARB_CTL_LEG2];
  wire ctl_vnd2  = ctl_q[`SMIARB_CTL_VND2];

  wire vnd_sum = |(ehci_vendor_sts & ehci_vendor_en);
  wire leg_sum = |(ehci_legacy_sts & ehci_legacy_en);

  wire tw_set = msg_evt
                | (alert_evt & twowire_smi_enable & ~alert_disable);

  wire src_usb  = ctl_leg & legacy_usb_event;
  wire src_vnd2 = ctl_vnd2 & vnd_sum;
  wire src_leg2 = ctl_leg2 & leg_sum;
  wire src_any = src_usb | rel_pend_q | tw_sts_q | src_vnd2 | src_leg2
                 | other_smi_event;
  wire pending = ctl_gbl & src_any;
  wire may_asrt  = ctl_rearm | ~first_done_q;
  wire do_asrt   = (state_q == ST_IDLE) & pending & may_asrt;
  wire rearm_wr1 = wr_ctl & io_wdata[`SMIARB_CTL_REARM];

  // ****************************************
  // control register
  // ****************************************
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      ctl_q <= `SMIARB_CONTROL_RST;
    end else begin
      if (wr_ctl) begin
        ctl_q <= io_wdata & `SMIARB_CONTROL_MASK;
      end
      if (do_asrt) begin
        ctl_q[`SMIARB_CTL_REARM] <= 1'b0;
      end
    end
  end

  // ****************************************
  // sticky status and release trap
  // ****************************************
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      tw_sts_q     <= 1'b0;
      rel_pend_q   <= 1'b0;
      msg_prev_q   <= 1'b0;
      alert_prev_q <= 1'b0;
    end else begin
      msg_prev_q   <= msg_sync;
      alert_prev_q <= alert_sync;
      if (tw_set) begin
        tw_sts_q <= 1'b1;
      end else if (wr_sts & io_wdata[`SMIARB_STS_TW]) begin
        tw_sts_q <= 1'b0;
      end
      if (global_release_bit & ctl_rel) begin
        rel_pend_q <= 1'b1;
      end else if (do_asrt) begin
        rel_pend_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // arbiter
  // ****************************************
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q           <= ST_IDLE;
      gap_cnt_q         <= 2'h0;
      first_done_q      <= 1'b0;
      system_mgmt_irq_n <= 1'b1;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (do_asrt) begin
            state_q           <= ST_ASRT;
            first_done_q      <= 1'b1;
            system_mgmt_irq_n <= 1'b0;
          end else if (rearm_wr1) begin
            state_q   <= ST_GAP;
            gap_cnt_q <= 2'h0;
          end
        end
        ST_ASRT: begin
          if (rearm_wr1) begin
            state_q           <= ST_GAP;
            gap_cnt_q         <= 2'h0;
            system_mgmt_irq_n <= 1'b1;
          end
        end
        ST_GAP: begin
          if (gap_cnt_q == `SMIARB_GAP_LAST) begin
            state_q <= ST_IDLE;
          end
          gap_cnt_q <= gap_cnt_q + 2'h1;
        end
        default: begin
          state_q           <= ST_IDLE;
          system_mgmt_irq_n <= 1'b1;
        end
      endcase
    end
  end

  // ****************************************
  // read port
  // ****************************************
  // status layout, reserved zero
  wire [31:0] sts_val = {13'h0, vnd_sum, leg_sum, tw_sts_q,
                         16'h0000};

  always @(posedge clk_sys) begin
    if (sys_rst) begin
      io_rdata <= `SMIARB_STATUS_RST;
    end else if (io_rd) begin
      if (io_addr == `SMIARB_STATUS_OFS) begin
        io_rdata <= sts_val;
      end else if (io_addr == `SMIARB_CONTROL_OFS) begin
        io_rdata <= ctl_q;
      end else begin
        io_rdata <= 32'h00000000;
      end
    end
  end
endmodule // smiarb_top
